// *** hw/serial_port_slave.sv ***
// Serial control port slave: select pins, I2C slave, buffered registers
module serial_port_slave (
  input wire logic link_clk,
  input wire logic rst_n,
  i2c_link_if.device link,
  input wire logic [1:0] port_select_upper_pin,
  input wire logic [1:0] port_select_lower_pin,
  output logic spi_selected,
  output logic update_pulse,
  output logic [serial_port_pkg::REG_COUNT*8-1:0] active_regs
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WR,
    ST_ACK,
    ST_RD,
    ST_MACK
  } slave_fsm_type;

  typedef struct packed {
    logic [1:0] up_s1;
    logic [1:0] up_s2;
    logic [1:0] lo_s1;
    logic [1:0] lo_s2;
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    slave_fsm_type state;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic rw;
    logic [1:0] byteidx;
    logic [15:0] addr;
    logic sda_low;
    logic upd;
    logic [serial_port_pkg::REG_COUNT-1:0][7:0] buffer_regs;
    logic [serial_port_pkg::REG_COUNT-1:0][7:0] active_store;
  } slave_regs_type;

  slave_regs_type st_r;
  slave_regs_type st_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic spi_mode;
  logic [6:0] own_addr;
  logic [serial_port_pkg::REG_INDEX_W-1:0] idx;

  // Three-level pin code to its count 0..2
  function automatic logic [2:0] level_value(input logic [1:0] code);
    case (code)
      serial_port_pkg::PIN_LOW: level_value = 3'h0;
      serial_port_pkg::PIN_OPEN: level_value = 3'h1;
      default: level_value = 3'h2;
    endcase
  endfunction : level_value

  // Select pins to slave address lower bits
  function automatic logic [2:0] select_lsbs(input logic [1:0] up, input logic [1:0] lo);
    select_lsbs = 3'((level_value(up) * 3'h3) + level_value(lo));
  endfunction : select_lsbs

  // Next state of the whole port
  always_comb begin
    st_nxt = st_r;
    st_nxt.upd = 1'b0;
    st_nxt.up_s1 = port_select_upper_pin;
    st_nxt.up_s2 = st_r.up_s1;
    st_nxt.lo_s1 = port_select_lower_pin;
    st_nxt.lo_s2 = st_r.lo_s1;
    st_nxt.scl_s1 = link.scl; // Input only: no SCL driver here
    st_nxt.scl_s2 = st_r.scl_s1;
    st_nxt.scl_p = st_r.scl_s2;
    st_nxt.sda_s1 = link.sda;
    st_nxt.sda_s2 = st_r.sda_s1;
    st_nxt.sda_p = st_r.sda_s2;
    // Oversampled edges hold at both bus rates
    scl_rise = st_r.scl_s2 && !st_r.scl_p;
    scl_fall = !st_r.scl_s2 && st_r.scl_p;
    start_seen = st_r.scl_s2 && st_r.scl_p && st_r.sda_p && !st_r.sda_s2;
    stop_seen = st_r.scl_s2 && st_r.scl_p && !st_r.sda_p && st_r.sda_s2;
    spi_mode = (st_r.up_s2 == serial_port_pkg::PIN_HIGH) && (st_r.lo_s2 == serial_port_pkg::PIN_HIGH);
    own_addr = {serial_port_pkg::SLAVE_ADDR_UPPER, select_lsbs(st_r.up_s2, st_r.lo_s2)};
    idx = st_r.addr[serial_port_pkg::REG_INDEX_W-1:0];
    if (spi_mode) begin
      st_nxt.state = ST_IDLE;
      st_nxt.sda_low = 1'b0;
    end else if (start_seen) begin
      // Start or repeated start drops any partial byte
      st_nxt.state = ST_ADDR;
      st_nxt.bitcnt = 4'h0;
      st_nxt.byteidx = 2'h0;
      st_nxt.sda_low = 1'b0;
    end else if (stop_seen) begin
      st_nxt.state = ST_IDLE; // Pointer kept after stop
      st_nxt.sda_low = 1'b0;
    end else begin
      case (st_r.state)
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            st_nxt.sh = {st_r.sh[6:0], st_r.sda_s2}; // MSB first
            st_nxt.bitcnt = st_r.bitcnt + 4'h1;
          end else if (scl_fall && st_r.bitcnt == serial_port_pkg::BYTE_BITS) begin
            st_nxt.bitcnt = 4'h0;
            if (st_r.state == ST_ADDR) begin
              if (st_r.sh[7:1] == own_addr) begin
                st_nxt.rw = st_r.sh[0];
                st_nxt.sda_low = 1'b1;
                st_nxt.state = ST_ACK;
              end else begin
                st_nxt.state = ST_IDLE;
              end
            end else begin
              st_nxt.sda_low = 1'b1;
              st_nxt.state = ST_ACK;
              case (st_r.byteidx)
                2'h0: st_nxt.addr = {st_r.sh, st_r.addr[7:0]}; // High byte first
                2'h1: st_nxt.addr = {st_r.addr[15:8], st_r.sh};
                default: begin
                  // Data lands in the buffer, pointer advances
                  st_nxt.buffer_regs[idx] = st_r.sh;
                  st_nxt.addr = st_r.addr + 16'h0001;
                  if (st_r.addr == serial_port_pkg::UPDATE_ADDR) begin
                    st_nxt.buffer_regs[idx][serial_port_pkg::UPDATE_BIT] = 1'b0; // Self-clearing
                    if (st_r.sh[serial_port_pkg::UPDATE_BIT]) begin
                      st_nxt.active_store = st_r.buffer_regs;
                      st_nxt.upd = 1'b1;
                    end
                  end
                end
              endcase
              if (st_r.byteidx != 2'h2) begin
                st_nxt.byteidx = st_r.byteidx + 2'h1;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            st_nxt.bitcnt = 4'h0;
            if (st_r.rw) begin
              // First read byte from current pointer, set while SCL low
              st_nxt.sh = st_r.buffer_regs[idx];
              st_nxt.sda_low = !st_r.buffer_regs[idx][7];
              st_nxt.addr = st_r.addr + 16'h0001;
              st_nxt.state = ST_RD;
            end else begin
              st_nxt.sda_low = 1'b0;
              st_nxt.state = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            st_nxt.bitcnt = st_r.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (st_r.bitcnt == serial_port_pkg::BYTE_BITS) begin
              st_nxt.sda_low = 1'b0; // Release for master acknowledge
              st_nxt.bitcnt = 4'h0;
              st_nxt.state = ST_MACK;
            end else begin
              st_nxt.sh = {st_r.sh[6:0], 1'b0};
              st_nxt.sda_low = !st_r.sh[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (st_r.sda_s2) begin
              st_nxt.state = ST_IDLE; // Nack: release, await stop
            end else begin
              st_nxt.bitcnt = serial_port_pkg::ACK_SEEN;
            end
          end else if (scl_fall && st_r.bitcnt == serial_port_pkg::ACK_SEEN) begin
            st_nxt.bitcnt = 4'h0;
            st_nxt.sh = st_r.buffer_regs[idx];
            st_nxt.sda_low = !st_r.buffer_regs[idx][7];
            st_nxt.addr = st_r.addr + 16'h0001;
            st_nxt.state = ST_RD;
          end
        end
        default: begin
          st_nxt.sda_low = 1'b0;
        end
      endcase
    end
  end

  // State register on the link clock
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.up_s1 <= serial_port_pkg::PIN_LOW;
      st_r.up_s2 <= serial_port_pkg::PIN_LOW;
      st_r.lo_s1 <= serial_port_pkg::PIN_LOW;
      st_r.lo_s2 <= serial_port_pkg::PIN_LOW;
      st_r.scl_s1 <= 1'b1;
      st_r.scl_s2 <= 1'b1;
      st_r.scl_p <= 1'b1;
      st_r.sda_s1 <= 1'b1;
      st_r.sda_s2 <= 1'b1;
      st_r.sda_p <= 1'b1;
      st_r.state <= ST_IDLE;
      st_r.addr <= serial_port_pkg::ADDR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Open-drain data pin and user outputs
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = st_r.sda_low;
  assign spi_selected = (st_r.up_s2 == serial_port_pkg::PIN_HIGH) && (st_r.lo_s2 == serial_port_pkg::PIN_HIGH);
  assign update_pulse = st_r.upd;
  assign active_regs = st_r.active_store;

endmodule : serial_port_slave

// *** hw/serial_port_pkg.sv ***
// Shared constants for the serial control port ends
package serial_port_pkg;
  // Three-level select pin codes
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_OPEN = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;
  // Fixed upper bits of the slave address
  localparam logic [3:0] SLAVE_ADDR_UPPER = 4'hB;
  // Register store geometry and the update control register
  localparam int REG_INDEX_W = 6;
  localparam int REG_COUNT = 64;
  localparam logic [15:0] UPDATE_ADDR = 16'h0232;
  localparam int UPDATE_BIT = 0;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  // Bus timing: SCL period per mode and system clock period
  localparam int SYS_CLK_PERIOD_NS = 20;
  localparam int SCL_STD_PERIOD_NS = 10000;
  localparam int SCL_FAST_PERIOD_NS = 2500;
  localparam int QUARTER_STD_CYC = (SCL_STD_PERIOD_NS + 4 * SYS_CLK_PERIOD_NS - 1) / (4 * SYS_CLK_PERIOD_NS);
  localparam int QUARTER_FAST_CYC = (SCL_FAST_PERIOD_NS + 4 * SYS_CLK_PERIOD_NS - 1) / (4 * SYS_CLK_PERIOD_NS);
  // Host command codes
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_STOP = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_READ = 2'h3;
  // Bit count marking a full byte and the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SEEN = 4'h9;
endpackage : serial_port_pkg

// *** hw/i2c_link_if.sv ***
// Two-wire link between the bus master and the slave port
interface i2c_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Open-drain wired-and with pull-ups
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);
  modport host (output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe,
                input scl, input sda);
  modport device (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface : i2c_link_if

// *** hw/serial_port_master.sv ***
// Two-wire bus master: divided SCL, byte-level command engine
module serial_port_master (
  input wire logic sys_clk,
  input wire logic rst_n,
  i2c_link_if.host link,
  input wire logic fast_mode,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);

  typedef enum logic [1:0] {
    MS_IDLE,
    MS_START,
    MS_STOP,
    MS_BYTE
  } master_fsm_type;

  typedef struct packed {
    logic sda_s1;
    logic sda_s2;
    master_fsm_type state;
    logic [1:0] ph;
    logic [7:0] cnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rd;
    logic last;
    logic ack_in;
    logic scl_hi;
    logic sda_hi;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nack;
  } master_regs_type;

  master_regs_type st_r;
  master_regs_type st_nxt;
  logic [7:0] reload;

  // Quarter-period divider and phase sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid = 1'b0;
    st_nxt.sda_s1 = link.sda;
    st_nxt.sda_s2 = st_r.sda_s1;
    reload = fast_mode ? 8'(serial_port_pkg::QUARTER_FAST_CYC - 1) : 8'(serial_port_pkg::QUARTER_STD_CYC - 1);
    if (st_r.state == MS_IDLE) begin
      if (cmd_valid) begin
        case (cmd_op)
          serial_port_pkg::CMD_START: st_nxt.state = MS_START;
          serial_port_pkg::CMD_STOP: st_nxt.state = MS_STOP;
          default: st_nxt.state = MS_BYTE;
        endcase
        st_nxt.rd = (cmd_op == serial_port_pkg::CMD_READ);
        st_nxt.sh = cmd_data;
        st_nxt.last = cmd_last;
        st_nxt.ph = 2'h0;
        st_nxt.bitn = 4'h0;
        st_nxt.cnt = reload;
      end
    end else if (st_r.cnt != 8'h00) begin
      st_nxt.cnt = st_r.cnt - 8'h01;
    end else begin
      st_nxt.cnt = reload;
      st_nxt.ph = st_r.ph + 2'h1;
      case (st_r.state)
        MS_START: begin
          // SDA falls while SCL high; also serves as repeated start
          case (st_r.ph)
            2'h0: begin
              st_nxt.scl_hi = 1'b0;
              st_nxt.sda_hi = 1'b1;
            end
            2'h1: st_nxt.scl_hi = 1'b1;
            2'h2: st_nxt.sda_hi = 1'b0;
            default: begin
              st_nxt.scl_hi = 1'b0;
              st_nxt.state = MS_IDLE;
              st_nxt.rsp_valid = 1'b1;
            end
          endcase
        end
        MS_STOP: begin
          // SDA rises while SCL high
          case (st_r.ph)
            2'h0: begin
              st_nxt.scl_hi = 1'b0;
              st_nxt.sda_hi = 1'b0;
            end
            2'h1: st_nxt.scl_hi = 1'b1;
            2'h2: st_nxt.sda_hi = 1'b1;
            default: begin
              st_nxt.state = MS_IDLE;
              st_nxt.rsp_valid = 1'b1;
            end
          endcase
        end
        MS_BYTE: begin
          case (st_r.ph)
            2'h0: begin
              // Data set up while SCL low
              st_nxt.scl_hi = 1'b0;
              if (st_r.bitn < serial_port_pkg::BYTE_BITS) begin
                st_nxt.sda_hi = st_r.rd | st_r.sh[7]; // MSB first
              end else begin
                st_nxt.sda_hi = !st_r.rd | st_r.last; // Nack on last read byte
              end
            end
            2'h1: st_nxt.scl_hi = 1'b1;
            2'h2: begin
              if (st_r.bitn < serial_port_pkg::BYTE_BITS) begin
                st_nxt.sh = {st_r.sh[6:0], st_r.sda_s2};
              end else begin
                st_nxt.ack_in = st_r.sda_s2;
              end
            end
            default: begin
              st_nxt.scl_hi = 1'b0;
              if (st_r.bitn == serial_port_pkg::BYTE_BITS) begin
                st_nxt.sda_hi = 1'b1;
                st_nxt.state = MS_IDLE;
                st_nxt.rsp_valid = 1'b1;
                st_nxt.rsp_data = st_r.sh;
                st_nxt.rsp_nack = st_r.ack_in;
              end else begin
                st_nxt.bitn = st_r.bitn + 4'h1;
              end
            end
          endcase
        end
        default: st_nxt.state = MS_IDLE;
      endcase
    end
  end

  // State register on the system clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.sda_s1 <= 1'b1;
      st_r.sda_s2 <= 1'b1;
      st_r.state <= MS_IDLE;
      st_r.scl_hi <= 1'b1;
      st_r.sda_hi <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Open-drain drivers and user outputs
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = !st_r.scl_hi;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = !st_r.sda_hi;
  assign cmd_ready = (st_r.state == MS_IDLE);
  assign rsp_valid = st_r.rsp_valid;
  assign rsp_data = st_r.rsp_data;
  assign rsp_nack = st_r.rsp_nack;

endmodule : serial_port_master

// *** tb/serial_port_properties.sv ***
// Wire and slave-output assertions for the serial control port link
module serial_port_properties (
  input wire logic sys_clk,
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic [1:0] port_select_upper_pin,
  input wire logic [1:0] port_select_lower_pin,
  input wire logic spi_selected,
  input wire logic update_pulse,
  input wire logic [serial_port_pkg::REG_COUNT*8-1:0] active_regs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q, sda_q, idle_r;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] shift_r, addr_r;
  logic scl_rise, start_ev, stop_ev, ack_slot, own_hit, sel_high;
  // Bus event decode and own address match
  assign scl_rise = scl && !scl_q;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev = scl && scl_q && !sda_q && sda;
  assign ack_slot = scl_rise && bit_cnt == 4'h8;
  assign sel_high = port_select_upper_pin[1] && port_select_lower_pin[1];
  assign own_hit = addr_r[7:1] == {4'hB, 3'(port_select_upper_pin * 3 + port_select_lower_pin)} && !sel_high;
  // Bit and byte tracking from the wire
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      idle_r <= 1'b0;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      shift_r <= 8'h00;
      addr_r <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev || stop_ev) begin
        bit_cnt <= 4'h0;
        byte_idx <= 2'h0;
        idle_r <= 1'b0;
      end else if (scl_rise) begin
        bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
        shift_r <= {shift_r[6:0], sda};
        if (bit_cnt == 4'h7 && byte_idx == 2'h0) addr_r <= {shift_r[6:0], sda};
        if (ack_slot && byte_idx != 2'h3) byte_idx <= byte_idx + 2'h1;
        if (ack_slot && sda && (byte_idx == 2'h0 || addr_r[0])) idle_r <= 1'b1;
      end
    end
  end
  a_addr_ack_own: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ack_slot && byte_idx == 2'h0 |-> (sda == 1'b0) == own_hit) else $error("address ack mismatch");
  a_write_byte_ack: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ack_slot && byte_idx != 2'h0 && !addr_r[0] && own_hit |-> !sda) else $error("write byte not acked");
  a_read_ack_free: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ack_slot && byte_idx != 2'h0 && addr_r[0] |-> !dev_sda_oe) else $error("slave drives read ack slot");
  a_dev_edge_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(dev_sda_oe) |-> !scl && !$past(scl)) else $error("slave data moved with clock high");
  a_idle_released: assert property (@(posedge sys_clk) disable iff (!rst_n)
    idle_r |-> !dev_sda_oe) else $error("slave drives while idle");
  a_ack_after_eight: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(dev_sda_oe) && !(addr_r[0] && byte_idx != 2'h0) |-> bit_cnt == 4'h8) else $error("ack not after bit 8");
  a_update_single: assert property (@(posedge link_clk) disable iff (!rst_n)
    update_pulse |=> !update_pulse) else $error("update pulse too long");
  a_active_on_update: assert property (@(posedge link_clk) disable iff (!rst_n)
    $changed(active_regs) |-> update_pulse || $past(update_pulse)) else $error("active copy moved alone");
  a_spi_mode: assert property (@(posedge link_clk) disable iff (!rst_n)
    sel_high [*5] |-> spi_selected) else $error("spi mode not selected");
  a_i2c_mode: assert property (@(posedge link_clk) disable iff (!rst_n)
    !sel_high [*5] |-> !spi_selected) else $error("spi mode wrongly selected");
  c_addr_ack: cover property (@(posedge sys_clk) ack_slot && byte_idx == 2'h0 && !sda);
  c_idle: cover property (@(posedge sys_clk) $rose(idle_r));
  c_update: cover property (@(posedge link_clk) update_pulse);
endmodule : serial_port_properties

// *** tb/testbench.sv ***
// Self-checking bench: master and slave joined over the two-wire link
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, fast_mode = 1'b1;
  logic cmd_valid = 1'b0, cmd_last = 1'b0, cmd_ready, rsp_valid, rsp_nack, spi_selected, update_pulse;
  logic [1:0] cmd_op = 2'h0, port_select_upper_pin = 2'h0, port_select_lower_pin = 2'h0;
  logic [7:0] cmd_data = 8'h00, rsp_data;
  logic [8:0] wire_sh = 9'h000;
  logic [serial_port_pkg::REG_COUNT*8-1:0] active_regs;
  logic [7:0] dat [4] = '{8'hC3, 8'h3C, 8'hA5, 8'h81};
  int num_errors = 0, total_checks = 0, cycles = 0, upd_cnt = 0;
  i2c_link_if link_if();
  serial_port_master serial_port_master_i (.sys_clk, .rst_n, .link(link_if.host), .fast_mode, .cmd_valid,
    .cmd_ready, .cmd_op, .cmd_data, .cmd_last, .rsp_valid, .rsp_data, .rsp_nack);
  serial_port_slave serial_port_slave_i (.link_clk, .rst_n, .link(link_if.device), .port_select_upper_pin,
    .port_select_lower_pin, .spi_selected, .update_pulse, .active_regs);
  serial_port_properties serial_port_properties_i (.sys_clk, .link_clk, .rst_n, .scl(link_if.scl),
    .sda(link_if.sda), .dev_sda_oe(link_if.dev_sda_oe), .port_select_upper_pin, .port_select_lower_pin,
    .spi_selected, .update_pulse, .active_regs);
  // Clocks of both domains
  always #10 sys_clk = ~sys_clk;
  always #7.5 link_clk = ~link_clk;
  // Wire bits at each clock rise, and update pulses
  always @(posedge link_if.scl) wire_sh <= {wire_sh[7:0], link_if.sda};
  always @(negedge link_clk) if (update_pulse === 1'b1) upd_cnt++;
  // Run ceiling
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 95000) begin
      num_errors++;
      test_done();
    end
  end
  task test_done;
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One command through the master, waiting for its response pulse
  task cmd(input logic [1:0] op, input logic [7:0] data, input logic last);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1 n++;
    end
    {cmd_op, cmd_data, cmd_last, cmd_valid} = {op, data, last, 1'b1};
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 6000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("response", 1'b1, rsp_valid);
    if (op[1]) chk("wire byte", {(op == serial_port_pkg::CMD_WRITE) ? data : rsp_data, rsp_nack}, wire_sh);
  endtask : cmd
  task st;
    cmd(serial_port_pkg::CMD_START, 8'h00, 1'b0);
  endtask : st
  task sp;
    cmd(serial_port_pkg::CMD_STOP, 8'h00, 1'b0);
  endtask : sp
  task wbyte(input logic [7:0] data, input logic nack);
    cmd(serial_port_pkg::CMD_WRITE, data, 1'b0);
    chk("ack bit", nack, rsp_nack);
  endtask : wbyte
  task rbyte(input logic [7:0] exp, input logic last);
    cmd(serial_port_pkg::CMD_READ, 8'h00, last);
    chk("read byte", exp, rsp_data);
  endtask : rbyte
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    // Every select pin combination against its slave address
    for (int u = 0; u < 3; u++) begin
      for (int l = 0; l < 3; l++) begin
        {port_select_upper_pin, port_select_lower_pin} = {2'(u), 2'(l)};
        repeat (8) @(posedge sys_clk);
        #1 st();
        wbyte({4'hB, 3'(u * 3 + l), 1'b0}, u == 2 && l == 2);
        sp();
        chk("spi select", u == 2 && l == 2, spi_selected);
      end
    end
    {port_select_upper_pin, port_select_lower_pin} = 4'h0;
    repeat (8) @(posedge sys_clk);
    #1 st();
    wbyte(8'hB2, 1'b1);
    sp();
    // Four data bytes from register 0x0010
    st();
    wbyte(8'hB0, 1'b0);
    wbyte(8'h00, 1'b0);
    wbyte(8'h10, 1'b0);
    for (int i = 0; i < 4; i++) wbyte(dat[i], 1'b0);
    sp();
    // Address-only write, then plain reads continuing after stop
    st();
    wbyte(8'hB0, 1'b0);
    wbyte(8'h00, 1'b0);
    wbyte(8'h11, 1'b0);
    sp();
    st();
    wbyte(8'hB1, 1'b0);
    rbyte(dat[1], 1'b0);
    rbyte(dat[2], 1'b1);
    sp();
    st();
    wbyte(8'hB1, 1'b0);
    rbyte(dat[3], 1'b1);
    sp();
    // Random read with repeated start at the slow rate
    fast_mode = 1'b0;
    st();
    wbyte(8'hB0, 1'b0);
    wbyte(8'h00, 1'b0);
    wbyte(8'h10, 1'b0);
    st();
    wbyte(8'hB1, 1'b0);
    rbyte(dat[0], 1'b1);
    sp();
    fast_mode = 1'b1;
    // Buffered data reaches the active copy only on update
    chk("active before", 8'h00, active_regs[8*16+:8]);
    st();
    wbyte(8'hB0, 1'b0);
    wbyte(8'h02, 1'b0);
    wbyte(8'h32, 1'b0);
    wbyte(8'h01, 1'b0);
    sp();
    repeat (8) @(posedge sys_clk);
    #1 chk("active after", dat[0], active_regs[8*16+:8]);
    chk("update count", 16'h0001, 16'(upd_cnt));
    test_done();
  end
endmodule : testbench
